// *** logic/udis_pkg.sv ***
// Constants shared by the device event status block
package udis_pkg;
   // ****************************************
   // Command codes and register layout
   // ****************************************
   localparam logic [7:0]  CMD_READ_EVENT_STATUS = 8'hC0;
   localparam logic [31:0] STATUS_RESET          = 32'h0000_0000;
   localparam logic [31:0] STATUS_IMPL_MASK      = 32'h00FF_FFBF;
   localparam int          BIT_BUS_RESET         = 0;
   localparam int          BIT_RESUME            = 1;
   localparam int          BIT_WENT_IDLE         = 2;
   localparam int          BIT_DMA_DONE          = 3;
   localparam int          BIT_SOF               = 4;
   localparam int          BIT_PSEUDO_FRAME      = 5;
   localparam int          BIT_SUSPENDED_NOW     = 7;
   localparam int          BIT_CTRL_OUT          = 8;
   localparam int          BIT_CTRL_IN           = 9;
   localparam int          BIT_EP_LOW            = 10;
   localparam int          EP_COUNT              = 14;

   // ****************************************
   // Timing
   // ****************************************
   localparam int          CLK_PERIOD_PS         = 4000;
   localparam int          CLK_MHZ               = 250;
   localparam int          FRAME_TIME_US         = 1000;
   localparam int          FRAME_CYCLES          = FRAME_TIME_US * CLK_MHZ;
   localparam int          RESET_MIN_NS          = 200;
   localparam int          RESET_MIN_CYCLES      = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                                   / CLK_PERIOD_PS;
   localparam logic [1:0]  MISSED_SOF_LIMIT      = 2'h3;
   localparam int          REF_OSC_MHZ           = 6;
   localparam int          PLL_MULT              = 8;
   localparam logic [8:0]  PLL_STEP              = 9'(REF_OSC_MHZ * PLL_MULT);
   localparam logic [8:0]  PLL_MODULUS           = 9'(CLK_MHZ);
   localparam logic [3:0]  PROGRAMMABLE_CLK_OUT_DIV_RESET      = 4'h0;
endpackage : udis_pkg

// *** logic/udis_status.sv ***
// Device event status word, its read command and the programmable clock output
// How it works
// RL1 - Command C0 starts a status read returned as two 16-bit words.
// RL2 - Host must read both words; abandoning after the first is illegal.
// RL3 - Bits 23..10 latch events of programmable endpoints 14..1.
// RL4 - Bit 9 latches control IN endpoint events.
// RL5 - Bit 8 latches control OUT endpoint events.
// RL6 - Bit 7 shows live bus state: 0 awake, 1 suspended.
// RL7 - Bit 5 set on each pseudo start-of-frame, every 1 ms.
// RL8 - Three consecutive missed start-of-frames put the device into suspend.
// RL9 - Bit 4 set whenever a start-of-frame is detected.
// RL10 - Bit 3 set when the DMA transfer counter reaches zero.
// RL11 - Bit 2 set on an awake to suspend change.
// RL12 - Bit 1 set when resume is detected on the bus.
// RL13 - Bit 0 set when a bus reset is detected.
// RL14 - Only sources enabled in the enable mask raise the interrupt request.
// RL15 - Reset input must be held low at least 200 ns.
// RL16 - A 48 MHz rate is derived from the 6 MHz reference.
// RL17 - Clock output derived from 48 MHz, programmable 3 to 48 MHz.
// RL18 - First word carries bits 15..0, second 31..16; reserved bits read zero.
`timescale 1ns/10ps

module udis_status #(
   parameter int FRAME_CYCLES = udis_pkg::FRAME_CYCLES  // Cycles per 1 ms frame
) (
   input  wire logic                      i_clk,                 // 250 MHz clock
   input  wire logic                      i_resetn,              // Async reset, active low
   input  wire logic                      i_cs_n,                // Chip select, active low
   input  wire logic                      i_rd_n,                // Read strobe, active low
   input  wire logic                      i_wr_n,                // Write strobe, active low
   input  wire logic                      i_a0,                  // 1 command, 0 data
   input  wire logic [15:0]               i_data,                // Data bus in
   output logic      [15:0]               o_data,                // Data bus out
   output logic                           o_data_oe,             // Data bus drive enable
   input  wire logic [udis_pkg::EP_COUNT-1:0] i_endpoint_pending, // Endpoint event pulses
   input  wire logic                      i_ctrl_in_pending,     // Control IN event pulse
   input  wire logic                      i_ctrl_out_pending,    // Control OUT event pulse
   input  wire logic                      i_bus_reset_seen,      // Bus reset detected pulse
   input  wire logic                      i_resume_seen,         // Resume detected pulse
   input  wire logic                      i_sof_seen,            // Start of frame pulse
   input  wire logic                      i_dma_count_done,      // DMA count zero pulse
   input  wire logic [31:0]               i_irq_enable,          // Interrupt enable mask
   input  wire logic [3:0]                i_programmable_clk_out_div,          // Clock out divider - 1
   output logic                           o_irq_request,         // Interrupt request
   output logic                           o_bus_suspended_now,   // Live suspend state
   output logic                           o_programmable_clk_out // Programmable clock
);

   // ****************************************
   // State
   // ****************************************
   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_LOW  = 2'b01,
      RD_HIGH = 2'b10
   } udis_rd_e;

   typedef struct packed {
      logic [31:0] status;
      logic [31:0] snapshot;
      udis_rd_e    rd_state;
      logic        word_taken;
      logic        rd_n_d;
      logic        wr_n_d;
      logic [15:0] data;
      logic [17:0] frame_cnt;
      logic [1:0]  missed;
      logic        sof_in_frame;
      logic        suspended;
      logic        irq;
      logic [8:0]  pll_acc;
      logic [3:0]  clk_cnt;
      logic        clk_out;
   } udis_state_s;

   udis_state_s st_reg;
   udis_state_s st_next;

   logic [31:0] set_bits;
   logic [31:0] clr_bits;
   logic        wr_fall;
   logic        rd_fall;
   logic        rd_rise;
   logic        frame_end;
   logic        tick_48;
   logic [9:0]  acc_sum;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      st_next  = st_reg;
      set_bits = '0;
      clr_bits = '0;
      wr_fall  = !i_cs_n && st_reg.wr_n_d && !i_wr_n;
      rd_fall  = !i_cs_n && st_reg.rd_n_d && !i_rd_n;
      rd_rise  = !st_reg.rd_n_d && i_rd_n;
      st_next.rd_n_d = i_rd_n;
      st_next.wr_n_d = i_wr_n;

      // Frame timer restarts on every real SOF; expiry is a pseudo SOF
      frame_end = (st_reg.frame_cnt == 18'(FRAME_CYCLES - 1));
      if (i_sof_seen || frame_end) begin
         st_next.frame_cnt = '0;
      end else begin
         st_next.frame_cnt = st_reg.frame_cnt + 18'h00001;
      end

      set_bits[udis_pkg::BIT_EP_LOW +: udis_pkg::EP_COUNT] = i_endpoint_pending; // [RL3]
      set_bits[udis_pkg::BIT_CTRL_IN]  = i_ctrl_in_pending;                      // [RL4]
      set_bits[udis_pkg::BIT_CTRL_OUT] = i_ctrl_out_pending;                     // [RL5]
      set_bits[udis_pkg::BIT_SOF]      = i_sof_seen;                             // [RL9]
      set_bits[udis_pkg::BIT_DMA_DONE] = i_dma_count_done;                       // [RL10]
      set_bits[udis_pkg::BIT_RESUME]   = i_resume_seen;                          // [RL12]
      set_bits[udis_pkg::BIT_BUS_RESET] = i_bus_reset_seen;                      // [RL13]
      set_bits[udis_pkg::BIT_PSEUDO_FRAME] = frame_end && !i_sof_seen;           // [RL7]

      // Missed SOF counting and suspend entry
      if (i_sof_seen || i_resume_seen || i_bus_reset_seen) begin
         st_next.missed    = '0;
         st_next.suspended = 1'b0;
      end else if (frame_end) begin
         if (st_reg.missed != udis_pkg::MISSED_SOF_LIMIT) begin
            st_next.missed = st_reg.missed + 2'h1;
         end
         if (st_reg.missed == udis_pkg::MISSED_SOF_LIMIT - 2'h1) begin           // [RL8]
            st_next.suspended = 1'b1;
         end
      end
      set_bits[udis_pkg::BIT_WENT_IDLE] = st_next.suspended && !st_reg.suspended; // [RL11]

      // Command and data phases of the host bus
      if (wr_fall && i_a0) begin
         st_next.word_taken = 1'b0;
         if (i_data[7:0] == udis_pkg::CMD_READ_EVENT_STATUS) begin               // [RL1]
            st_next.rd_state = RD_LOW;
            st_next.snapshot = st_reg.status;
         end else begin
            st_next.rd_state = RD_IDLE;
         end
      end else begin
         unique case (st_reg.rd_state)
            RD_IDLE: begin
               st_next.data = st_reg.data;
            end
            RD_LOW: begin
               if (rd_fall && !i_a0) begin
                  st_next.data = st_reg.snapshot[15:0];                          // [RL18]
                  st_next.data[udis_pkg::BIT_SUSPENDED_NOW] = st_reg.suspended;  // [RL6]
                  st_next.word_taken = 1'b1;
               end
               // Strobes meant for other chips must not advance the read
               if (rd_rise && st_reg.word_taken) begin
                  st_next.rd_state   = RD_HIGH;
                  st_next.word_taken = 1'b0;
               end
            end
            RD_HIGH: begin
               if (rd_fall && !i_a0) begin
                  st_next.data = st_reg.snapshot[31:16];                         // [RL18]
                  st_next.word_taken = 1'b1;
               end
               // Clear only what was reported; the host relies on both reads [RL2]
               if (rd_rise && st_reg.word_taken) begin
                  st_next.rd_state   = RD_IDLE;
                  st_next.word_taken = 1'b0;
                  clr_bits = st_reg.snapshot;
               end
            end
            default: begin
               st_next.rd_state = RD_IDLE;
            end
         endcase
      end

      // Set wins over the read clear
      st_next.status = ((st_reg.status & ~clr_bits) | set_bits) & udis_pkg::STATUS_IMPL_MASK;
      st_next.status[udis_pkg::BIT_SUSPENDED_NOW] = st_next.suspended;           // [RL6]
      st_next.irq = |(st_next.status & i_irq_enable);                            // [RL14]

      // 48 MHz rate enable: step 48 per 250 MHz cycle, modulo 250
      acc_sum = {1'b0, st_reg.pll_acc} + {1'b0, udis_pkg::PLL_STEP};             // [RL16]
      tick_48 = (acc_sum >= {1'b0, udis_pkg::PLL_MODULUS});
      st_next.pll_acc = tick_48 ? 9'(acc_sum - {1'b0, udis_pkg::PLL_MODULUS})
                                : acc_sum[8:0];

      // Output frequency is 48 / (div + 1) MHz; div 0 passes the enable itself
      if (i_programmable_clk_out_div == udis_pkg::PROGRAMMABLE_CLK_OUT_DIV_RESET) begin                      // [RL17]
         st_next.clk_cnt = '0;
         st_next.clk_out = tick_48;
      end else begin
         if (tick_48) begin
            st_next.clk_cnt = (st_reg.clk_cnt >= i_programmable_clk_out_div) ? 4'h0
                                                               : st_reg.clk_cnt + 4'h1;
         end
         st_next.clk_out = (st_next.clk_cnt <= (i_programmable_clk_out_div >> 1));             // [RL17]
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   // Reset must be held at least RESET_MIN_CYCLES clocks by the system [RL15]
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_reg              <= '0;
         st_reg.status       <= udis_pkg::STATUS_RESET;
         st_reg.snapshot     <= udis_pkg::STATUS_RESET;
         st_reg.rd_state     <= RD_IDLE;
         st_reg.rd_n_d       <= 1'b1;
         st_reg.wr_n_d       <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign o_data                 = st_reg.data;
   assign o_data_oe              = !i_cs_n && !i_rd_n && !i_a0 && !st_reg.rd_n_d
                                   && (st_reg.rd_state != RD_IDLE);
   assign o_irq_request          = st_reg.irq;
   assign o_bus_suspended_now    = st_reg.suspended;
   assign o_programmable_clk_out = st_reg.clk_out;

endmodule : udis_status

// *** testbench/udis_status_assertions.sv ***
// Concurrent checks on the ports of the device event status block
`timescale 1ns/10ps
module udis_status_assertions #(
   parameter int FRAME_CYCLES = udis_pkg::FRAME_CYCLES  // Cycles per frame
) (
   input wire logic        i_clk,                  // Clock
   input wire logic        i_resetn,               // Reset, active low
   input wire logic        i_cs_n,                 // Chip select
   input wire logic        i_rd_n,                 // Read strobe
   input wire logic        i_a0,                   // Phase select
   input wire logic [15:0] o_data,                 // Read data
   input wire logic        o_data_oe,              // Drive enable
   input wire logic        i_sof_seen,             // Frame start
   input wire logic        i_resume_seen,          // Resume
   input wire logic        i_bus_reset_seen,       // Bus reset
   input wire logic        i_dma_count_done,       // DMA done
   input wire logic [31:0] i_irq_enable,           // Enable mask
   input wire logic        o_irq_request,          // Interrupt request
   input wire logic        o_bus_suspended_now,    // Suspend state
   input wire logic        o_programmable_clk_out  // Clock out
);
   // ****************************************
   // Helper counter and checks
   // ****************************************
   int quiet;
   // Cycles since the bus last showed activity
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) quiet <= 0;
      else if (i_sof_seen || i_resume_seen || i_bus_reset_seen) quiet <= 0;
      else if (quiet < 100000) quiet <= quiet + 1;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_mask_off;
      (i_irq_enable == 32'h0000_0000) [*3];
   endsequence
   chk_oe_needs_rd: assert property (o_data_oe |-> !i_cs_n && !i_rd_n && !i_a0)
      else $error("data driven outside a read");
   chk_data_holds: assert property (o_data_oe && $past(o_data_oe) |-> $stable(o_data))
      else $error("read data moved while driven");
   chk_irq_enabled: assert property (i_dma_count_done && i_irq_enable[3] |-> ##[2:3] o_irq_request)
      else $error("enabled event raised no request");
   chk_irq_masked: assert property (s_mask_off |-> !o_irq_request)
      else $error("request with all sources masked");
   chk_sof_wakes: assert property (i_sof_seen |-> ##[1:2] !o_bus_suspended_now)
      else $error("frame start did not wake the bus");
   chk_suspend_late: assert property ($rose(o_bus_suspended_now) |-> quiet >= 3 * FRAME_CYCLES - 4)
      else $error("suspend before three missed frames");
   chk_suspend_due: assert property (quiet == 3 * FRAME_CYCLES + 4 |-> o_bus_suspended_now)
      else $error("no suspend after three missed frames");
   chk_programmable_clk_out_runs: assert property (1'b1 |-> ##[1:100] $rose(o_programmable_clk_out))
      else $error("clock output stalled");
   chk_reset_clear: assert property ($rose(i_resetn) |-> o_data == 16'h0000 && !o_irq_request)
      else $error("outputs not cleared by reset");
endmodule : udis_status_assertions

// *** testbench/udis_host_model.sv ***
// Host processor model on the command and data bus
`timescale 1ns/10ps
module udis_host_model (
   input  wire logic [15:0] i_data,  // Read data
   input  wire logic        i_clk,   // Clock
   output logic             o_cs_n,  // Chip select
   output logic             o_rd_n,  // Read strobe
   output logic             o_wr_n,  // Write strobe
   output logic             o_a0,    // Phase select
   output logic [15:0]      o_data   // Write data
);
   // ****************************************
   // Bus cycles
   // ****************************************
   initial begin
      {o_cs_n, o_rd_n, o_wr_n, o_a0} = 4'hF;
      o_data = 16'h5A5A;
   end
   task automatic cmd(input logic [7:0] code);
      @(posedge i_clk);
      #1;
      {o_cs_n, o_a0, o_wr_n} = 3'h2;
      o_data = {8'h00, code};
      @(posedge i_clk);
      #1;
      o_wr_n = 1'b1;
      o_data = ~o_data;  // Released lines must not keep the last value
   endtask : cmd
   task automatic rdw(output logic [15:0] w);
      @(posedge i_clk);
      #1;
      {o_a0, o_rd_n} = 2'h0;
      repeat (3) @(posedge i_clk);
      w = i_data;
      #1;
      o_rd_n = 1'b1;
      @(posedge i_clk);
   endtask : rdw
   task automatic rd_status(output logic [31:0] v);
      cmd(udis_pkg::CMD_READ_EVENT_STATUS);
      rdw(v[15:0]);
      rdw(v[31:16]);  // Never abandoned after one word
   endtask : rd_status
endmodule : udis_host_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the device event status block
`timescale 1ns/10ps
module tb_top;
   localparam int FC = 50;
   logic        i_clk, i_resetn, cs_n, rd_n, wr_n, a0, irq, susp, ck_out, oe;
   logic [15:0] d_wr, d_rd;
   logic [19:0] ev;
   logic [31:0] en, got;
   logic [3:0]  div;
   int          num_errors = 0, num_checks = 0;
   udis_status #(.FRAME_CYCLES(FC)) i_udis_status (.i_clk(i_clk), .i_resetn(i_resetn),
      .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_a0(a0), .i_data(d_wr), .o_data(d_rd),
      .o_data_oe(oe), .i_endpoint_pending(ev[19:6]), .i_ctrl_in_pending(ev[5]),
      .i_ctrl_out_pending(ev[4]), .i_bus_reset_seen(ev[3]), .i_resume_seen(ev[2]),
      .i_sof_seen(ev[1]), .i_dma_count_done(ev[0]), .i_irq_enable(en), .i_programmable_clk_out_div(div),
      .o_irq_request(irq), .o_bus_suspended_now(susp), .o_programmable_clk_out(ck_out));
   udis_host_model i_udis_host_model (.i_data(d_rd), .i_clk(i_clk), .o_cs_n(cs_n),
      .o_rd_n(rd_n), .o_wr_n(wr_n), .o_a0(a0), .o_data(d_wr));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask : chk32
   task automatic chk1(input string n, input logic e, input logic g);
      chk32(n, {31'h0, e}, {31'h0, g});
   endtask : chk1
   task automatic fire(input logic [19:0] v);
      @(posedge i_clk);
      #1;
      ev = v;
      @(posedge i_clk);
      #1;
      ev = 20'h00000;
      repeat (3) @(posedge i_clk);
   endtask : fire
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_all;
      fire(20'hFFFFF);
      chk1("irq", 1'b1, irq);
      i_udis_host_model.rd_status(got);
      chk32("status", 32'h00FF_FF1B, got);
      repeat (3) @(posedge i_clk);
      chk1("irq", 1'b0, irq);
      i_udis_host_model.rd_status(got);
      chk32("cleared", 32'h0000_0000, got);
   endtask : t_all
   task automatic t_mask;
      @(posedge i_clk);
      #1;
      en = 32'h0000_0000;
      fire(20'h00003);
      chk1("irq", 1'b0, irq);
      i_udis_host_model.rd_status(got);
      chk32("status", 32'h0000_0018, got);
   endtask : t_mask
   task automatic t_susp;
      @(posedge i_clk);
      #1;
      div = 4'hF;
      repeat (3 * FC + 10) @(posedge i_clk);
      chk1("susp", 1'b1, susp);
      i_udis_host_model.rd_status(got);
      chk32("status", 32'h0000_00A4, got);
      fire(20'h00002);
      chk1("susp", 1'b0, susp);
   endtask : t_susp
   // Rising edges of the clock output over 1 us: 48 / (div + 1) expected
   task automatic t_clk(input logic [3:0] d, input logic [31:0] e);
      int   n;
      logic p;
      n = 0;
      @(posedge i_clk);
      #1;
      div = d;
      repeat (20) @(posedge i_clk);
      #1;
      p = ck_out;
      repeat (250) begin
         @(posedge i_clk);
         #1;
         if (ck_out && !p) n++;
         p = ck_out;
      end
      chk32("clk rises", e, 32'(n));
   endtask : t_clk
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   initial begin
      repeat (3000) @(posedge i_clk);
      num_errors++;
      wrap_up();
   end
   initial begin
      {i_resetn, ev, en, div} = {1'b0, 20'h00000, 32'hFFFF_FFFF, 4'h0};
      repeat (50) @(posedge i_clk);  // Long enough for a full internal reset
      #1;
      i_resetn = 1'b1;
      repeat (2) @(posedge i_clk);
      t_all();
      t_mask();
      t_susp();
      t_clk(4'h0, 32'h0000_0030);
      t_clk(4'hF, 32'h0000_0003);
      wrap_up();
   end
endmodule : tb_top
bind udis_status udis_status_assertions #(.FRAME_CYCLES(FRAME_CYCLES)) i_udis_status_assertions (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_a0(i_a0),
   .o_data(o_data), .o_data_oe(o_data_oe), .i_sof_seen(i_sof_seen),
   .i_resume_seen(i_resume_seen), .i_bus_reset_seen(i_bus_reset_seen),
   .i_dma_count_done(i_dma_count_done), .i_irq_enable(i_irq_enable),
   .o_irq_request(o_irq_request), .o_bus_suspended_now(o_bus_suspended_now),
   .o_programmable_clk_out(o_programmable_clk_out));
